// *** logic/csp_pkg.sv ***
/*
 * Shared constants, types and the register map of the compass status and power
 * command block.
 * Assumes a 100 MHz system clock and a byte-wide serial receiver and transmitter
 * on the same clock.
 */
package csp_pkg;

    localparam int          CLK_HZ        = 100_000_000;
    localparam int          WAKE_HOLD_MS  = 100;
    localparam longint      WAKE_HOLD_CYC = (longint'(WAKE_HOLD_MS) * CLK_HZ + 999) / 1000;

    localparam logic [7:0]  CH_WAKE       = 8'h7a;
    localparam logic [7:0]  CH_STATUS     = 8'h49;
    localparam logic [7:0]  CH_START      = 8'h53;
    localparam logic [7:0]  CH_CR         = 8'h0d;
    localparam logic [63:0] SHUT_WORD     = 64'h53687574646f776e;
    localparam logic [3:0]  SHUT_LEN      = 4'h8;

    localparam int          PAY_CHARS     = 23;
    localparam logic [4:0]  IDX_PAY_LAST  = 5'h17;
    localparam logic [4:0]  IDX_CHK_HI    = 5'h18;
    localparam logic [4:0]  IDX_CHK_LO    = 5'h19;
    localparam logic [4:0]  IDX_LAST      = 5'h1a;

    localparam logic [7:0]  RATE_CODE [4] = '{8'h0a, 8'h05, 8'h01, 8'h00};
    localparam logic [3:0]  MODE_CONT     = 4'h1;
    localparam logic [3:0]  MODE_SINGLE   = 4'h3;
    localparam logic [7:0]  CPU_PASS      = 8'hff;
    localparam logic [7:0]  CPU_FAIL      = 8'h7f;
    localparam logic [7:0]  TMP_PASS      = 8'hff;
    localparam logic [7:0]  TMP_FAIL      = 8'hfb;

    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_RANGE     = 8'h04;
    localparam logic [7:0]  OFF_TEMP      = 8'h08;
    localparam logic [7:0]  OFF_SELFTEST  = 8'h0c;
    localparam logic [7:0]  OFF_STATE     = 8'h10;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;

    localparam logic [2:0]  CTRL_RST      = 3'h0;
    localparam logic [15:0] RANGE_RST     = 16'h7fff;
    localparam logic [7:0]  TEMP_RST      = 8'h00;
    localparam logic [1:0]  SELF_RST      = 2'h3;
    localparam int          IRQ_W         = 4;
    localparam int          IRQ_WAKE      = 0;
    localparam int          IRQ_SHUT      = 1;
    localparam int          IRQ_SENT      = 2;
    localparam int          IRQ_DROP      = 3;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_SETTLE,
        ST_ASLEEP
    } csp_pwr_e;

    typedef struct packed {
        logic [7:0]  sw_ver;
        logic [7:0]  hw_ver;
        logic [15:0] unused_a;
        logic [7:0]  rate;
        logic [7:0]  unused_b;
        logic [15:0] range;
        logic [7:0]  temp;
        logic [3:0]  mode;
        logic [7:0]  cpu;
        logic [7:0]  tmp;
    } csp_frame_s;

endpackage

// *** logic/csp_top.sv ***
/*
 * Command interpreter for wake, shutdown and status request, with the status
 * frame generator and a small register file with interrupt.
 * Assumes the received and transmitted bytes come from a serial unit on sys_clk_i.
 */
`timescale 1ns/1ns
// How it works
// - Wake character leaves sleep, no reply.
// - Shutdown plus CR enters sleep silently.
// - Only the wake character ends sleep.
// - Character I sends the status frame.
// - Frame is 27 chars, S first, CR last.
// - Numeric fields are hex, high digit first.
// - Versions, zero fields and range in place.
// - Characters 18-19 carry signed temperature.
// - Character 20 gives mode 1 or 3.
// - Processor status FF pass, 7F fail.
// - Temperature status FF pass, FB fail.
// - Valid only when both self-tests pass.
// - Checksum sums characters 2 to 24.
// - Valid in bit 7, sum in bits 6-0.
// - Continuous and on-request reporting modes exist; continuous only sets mode 1 and cont_mode_o, frames still go on I.
// - Mode resets to on-request reporting.
module csp_top
    import csp_pkg::*;
#(
    parameter logic [7:0]  SW_VERSION = 8'h00,
    parameter logic [7:0]  HW_VERSION = 8'h00,
    parameter longint      HOLD_CYC   = WAKE_HOLD_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    input  wire logic        tx_ready_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic [31:0]      reg_rdata_o,
    output logic             sleep_o,
    output logic             cont_mode_o,
    output logic             irq_o
);

    if (HOLD_CYC < 1 || HOLD_CYC >= 64'h0000_0000_0100_0000) begin : g_chk
        $error("HOLD_CYC must lie between 1 and 2**24-1");
    end

    localparam logic [23:0] HOLD_LAST = 24'(HOLD_CYC - 1);

    csp_pwr_e          pwr_q;
    logic [23:0]       hold_q;
    logic [3:0]        match_q;
    logic              busy_q;
    logic [4:0]        idx_q;
    logic [7:0]        tx_data_q;
    csp_frame_s        frm_q;
    logic              mode_cont_q;
    logic [1:0]        rate_sel_q;
    logic [15:0]       range_q;
    logic [7:0]        temp_q;
    logic              cpu_ok_q;
    logic              tmp_ok_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [31:0]       rdata_q;

    logic              rx_take;
    logic              awake;
    logic              asleep;
    logic              hold_done;
    logic [7:0]        shut_ch;
    logic              wake_hit;
    logic              shut_hit;
    logic              stat_hit;
    logic              drop_hit;
    logic              tx_step;
    logic              sent_hit;
    logic              valid_bit;
    logic [7:0]        sum8;
    logic [7:0]        chk;
    logic [7:0]        next_ch;
    logic [91:0]       frm_bits;
    logic [7:0]        pay_asc [PAY_CHARS];
    logic [IRQ_W-1:0]  irq_ev;
    csp_frame_s        frm_now;

    function automatic logic [7:0] hex_c(input logic [3:0] n);
        hex_c = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.

    assign rx_take   = ce_i & rx_valid_i;
    assign awake     = (pwr_q == ST_AWAKE);
    assign asleep    = (pwr_q == ST_ASLEEP);
    assign hold_done = (hold_q == HOLD_LAST);
    assign shut_ch   = SHUT_WORD[8'd63 - {2'h0, match_q[2:0], 3'h0} -: 8];

    assign wake_hit  = rx_take & asleep & (rx_data_i == CH_WAKE);
    assign shut_hit  = rx_take & awake & (match_q == SHUT_LEN) & (rx_data_i == CH_CR);
    assign stat_hit  = rx_take & awake & ~busy_q & (rx_data_i == CH_STATUS);
    // A status request arriving mid-frame is dropped rather than queued, so the
    // host always sees whole frames.
    assign drop_hit  = rx_take & ((asleep & ~wake_hit)
                                  | (pwr_q == ST_SETTLE)
                                  | (awake & busy_q & (rx_data_i == CH_STATUS)));

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_q <= 4'h0;
        end else if (ce_i) begin
            if (!awake) begin
                match_q <= 4'h0;
            end else if (rx_take) begin
                if (match_q < SHUT_LEN && rx_data_i == shut_ch) begin
                    match_q <= match_q + 4'h1;
                end else if (rx_data_i == CH_START) begin
                    match_q <= 4'h1;
                end else begin
                    match_q <= 4'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state.

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwr_q <= ST_AWAKE;
        end else if (ce_i) begin
            case (pwr_q)
                ST_AWAKE: begin
                    if (shut_hit) begin
                        pwr_q <= ST_ASLEEP;
                    end
                end
                ST_SETTLE: begin
                    if (hold_done) begin
                        pwr_q <= ST_AWAKE;
                    end
                end
                ST_ASLEEP: begin
                    if (wake_hit) begin
                        pwr_q <= ST_SETTLE;
                    end
                end
                default: begin
                    pwr_q <= ST_AWAKE;
                end
            endcase
        end
    end

    // The host owes a quiet period after waking; commands inside it are dropped
    // because the sensors may not have settled yet.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_q <= 24'h0;
        end else if (ce_i) begin
            if (pwr_q == ST_SETTLE && !hold_done) begin
                hold_q <= hold_q + 24'h1;
            end else begin
                hold_q <= 24'h0;
            end
        end
    end

    assign sleep_o = asleep;

    ////////////////////////////////////////////////////////////////////////////
    // Status frame contents, frozen at the request.

    always_comb begin
        frm_now          = '0;
        frm_now.sw_ver   = SW_VERSION;
        frm_now.hw_ver   = HW_VERSION;
        frm_now.rate     = RATE_CODE[rate_sel_q];
        frm_now.range    = range_q;
        frm_now.temp     = temp_q;
        frm_now.mode     = mode_cont_q ? MODE_CONT : MODE_SINGLE;
        frm_now.cpu      = cpu_ok_q ? CPU_PASS : CPU_FAIL;
        frm_now.tmp      = tmp_ok_q ? TMP_PASS : TMP_FAIL;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frm_q <= '0;
        end else if (ce_i && stat_hit) begin
            frm_q <= frm_now;
        end
    end

    assign frm_bits = frm_q;

    for (genvar k = 0; k < PAY_CHARS; k++) begin : g_pay
        assign pay_asc[k] = hex_c(frm_bits[91 - 4 * k -: 4]);
    end

    always_comb begin
        sum8 = 8'h00;
        for (int k = 0; k < PAY_CHARS; k++) begin
            sum8 = sum8 + pay_asc[k];
        end
    end

    // Bit 7 belongs to the valid flag, so the sum's own bit 7 is not sent.
    assign valid_bit = (frm_q.cpu == CPU_PASS) && (frm_q.tmp == TMP_PASS);
    assign chk       = {valid_bit, sum8[6:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Frame transmitter.

    assign tx_step  = ce_i & busy_q & tx_ready_i;
    assign sent_hit = tx_step & (idx_q == IDX_LAST);

    always_comb begin
        next_ch = CH_CR;
        if (idx_q < IDX_PAY_LAST) begin
            next_ch = pay_asc[idx_q];
        end else if (idx_q == IDX_PAY_LAST) begin
            next_ch = hex_c(chk[7:4]);
        end else if (idx_q == IDX_CHK_HI) begin
            next_ch = hex_c(chk[3:0]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q    <= 1'b0;
            idx_q     <= 5'h00;
            tx_data_q <= 8'h00;
        end else if (ce_i) begin
            if (stat_hit) begin
                busy_q    <= 1'b1;
                idx_q     <= 5'h00;
                tx_data_q <= CH_START;
            end else if (tx_step) begin
                if (idx_q == IDX_LAST) begin
                    busy_q <= 1'b0;
                end else begin
                    idx_q     <= idx_q + 5'h01;
                    tx_data_q <= next_ch;
                end
            end
        end
    end

    assign tx_valid_o = busy_q;
    assign tx_data_o  = tx_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {rate_sel_q, mode_cont_q} <= CTRL_RST;
        end else if (ce_i && reg_we_i && reg_addr_i == OFF_CTRL) begin
            {rate_sel_q, mode_cont_q} <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            range_q <= RANGE_RST;
            temp_q  <= TEMP_RST;
            {tmp_ok_q, cpu_ok_q} <= SELF_RST;
        end else if (ce_i && reg_we_i) begin
            if (reg_addr_i == OFF_RANGE) begin
                range_q <= reg_wdata_i[15:0];
            end
            if (reg_addr_i == OFF_TEMP) begin
                temp_q <= reg_wdata_i[7:0];
            end
            if (reg_addr_i == OFF_SELFTEST) begin
                {tmp_ok_q, cpu_ok_q} <= reg_wdata_i[1:0];
            end
        end
    end

    assign irq_ev = {drop_hit, sent_hit, shut_hit, wake_hit};

    // A new event beats a write-one-to-clear in the same cycle.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else if (ce_i) begin
            if (reg_we_i && reg_addr_i == OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata_i[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (reg_we_i && reg_addr_i == OFF_IRQ_MASK) begin
                irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0;
        end else if (ce_i) begin
            rdata_q <= 32'h0;
            if (reg_re_i) begin
                case (reg_addr_i)
                    OFF_CTRL:     rdata_q <= {29'h0, rate_sel_q, mode_cont_q};
                    OFF_RANGE:    rdata_q <= {16'h0, range_q};
                    OFF_TEMP:     rdata_q <= {24'h0, temp_q};
                    OFF_SELFTEST: rdata_q <= {30'h0, tmp_ok_q, cpu_ok_q};
                    OFF_STATE:    rdata_q <= {29'h0, busy_q, pwr_q == ST_SETTLE, asleep};
                    OFF_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
                    OFF_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
                    default:      rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign cont_mode_o = mode_cont_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_wake;
        wake_hit |=> !sleep_o && !tx_valid_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not leave sleep quietly");

    property p_settle;
        wake_hit |=> (pwr_q == ST_SETTLE);
    endproperty
    a_settle: assert property (p_settle) else $error("no hold-off after wake");

    property p_shut;
        shut_hit && !busy_q |=> sleep_o && !tx_valid_o;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown did not sleep");

    property p_sleep_exit;
        $fell(sleep_o) |-> $past(wake_hit);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left without wake");

    property p_status;
        stat_hit |=> tx_valid_o && tx_data_o == CH_START && idx_q == 5'h00;
    endproperty
    a_status: assert property (p_status) else $error("status frame did not start");

    property p_end;
        tx_step && idx_q == IDX_LAST |-> tx_data_o == CH_CR ##1 !tx_valid_o;
    endproperty
    a_end: assert property (p_end) else $error("frame does not end in CR at 27");

    property p_hex;
        tx_valid_o && idx_q != 5'h00 && idx_q != IDX_LAST |->
            (tx_data_o inside {[8'h30:8'h39], [8'h41:8'h46]});
    endproperty
    a_hex: assert property (p_hex) else $error("frame digit is not hex");

    property p_cpu;
        stat_hit |=> frm_q.cpu == (cpu_ok_q ? CPU_PASS : CPU_FAIL);
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu status field wrong");

    property p_tmp;
        stat_hit |=> frm_q.tmp == (tmp_ok_q ? TMP_PASS : TMP_FAIL);
    endproperty
    a_tmp: assert property (p_tmp) else $error("temperature status field wrong");

    // The high checksum digit is 8 or above exactly when the valid flag is set.
    property p_valid;
        tx_step && idx_q == IDX_PAY_LAST |=>
            (tx_data_o >= 8'h38) == (frm_q.cpu == CPU_PASS && frm_q.tmp == TMP_PASS);
    endproperty
    a_valid: assert property (p_valid) else $error("valid bit wrong");

    property p_drop;
        rx_take && asleep && rx_data_i != CH_WAKE |=> sleep_o && !tx_valid_o;
    endproperty
    a_drop: assert property (p_drop) else $error("sleeping block answered");

endmodule

// *** testbench/csp_host.sv ***
/*
 * Host model on the far side of the serial link: sends command bytes, takes frame bytes.
 * Assumes byte ports on the block's clock, with a one-cycle receive pulse per byte.
 */
`timescale 1ns/1ns
module csp_host
    import csp_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            tx_ready_o
);
    logic [7:0] got_q [$];
    logic       stall = 1'b0;

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        tx_ready_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A stalled host is ready only every other cycle, so the block must hold each byte until taken.
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_data_i);
        end
        tx_ready_o <= stall ? ~tx_ready_o : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic send_byte(input logic [7:0] b);
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o  <= b;
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        // Idle data is inverted so that a stale byte cannot pass for a fresh one.
        rx_data_o  <= ~b;
    endtask

    task automatic send_word(input string s);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(s[i]);
        end
    endtask

    task automatic wake;
        send_byte(CH_WAKE);
    endtask

    task automatic hold_off(input int hold);
        repeat (hold + 4) @(posedge sys_clk_i);
    endtask
endmodule

// *** testbench/csp_top_tb_top.sv ***
/*
 * Self-checking bench for the status, wake and shutdown command block.
 * Assumes the host model in csp_host and a shortened wake hold-off.
 */
`timescale 1ns/1ns
module csp_top_tb_top;
    import csp_pkg::*;
    localparam int HOLD = 20;

    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        ce      = 1'b1;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_we    = 1'b0;
    logic        reg_re    = 1'b0;
    logic [31:0] reg_rdata;
    logic        sleep;
    logic        cont_mode;
    logic        irq;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          cycles  = 0;

    always #5 sys_clk = ~sys_clk;

    csp_top #(.HOLD_CYC(HOLD)) u_csp_top (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(ce),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_ready_i(tx_ready), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
        .reg_rdata_o(reg_rdata), .sleep_o(sleep), .cont_mode_o(cont_mode), .irq_o(irq));

    csp_host u_csp_host (
        .sys_clk_i(sys_clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_ready_o(tx_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The ceiling is far above the few hundred cycles the scenarios need.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_we    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    // Builds the expected frame from the field values and compares it byte by byte.
    task automatic expect_frame(input logic [7:0] rate, input logic [15:0] rng,
                                input logic [7:0] tc, input logic [3:0] mode,
                                input logic [7:0] cpu, input logic [7:0] tst);
        logic [7:0]  exp_q [$];
        logic [7:0]  sum;
        logic [91:0] pay;
        int          k;
        pay = {8'h00, 8'h00, 16'h0000, rate, 8'h00, rng, tc, mode, cpu, tst};
        sum = 8'h00;
        exp_q.push_back(8'h53);
        for (k = 22; k >= 0; k--) begin
            exp_q.push_back(hx(pay[k*4 +: 4]));
            sum = sum + hx(pay[k*4 +: 4]);
        end
        sum = {(cpu == 8'hff && tst == 8'hff), sum[6:0]};
        exp_q.push_back(hx(sum[7:4]));
        exp_q.push_back(hx(sum[3:0]));
        exp_q.push_back(8'h0d);
        k = 0;
        while (u_csp_host.got_q.size() < 27 && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        repeat (6) @(posedge sys_clk);
        check(u_csp_host.got_q.size(), 27, "frame length");
        check(tx_valid, 1'b0, "frame end");
        for (k = 0; k < 27 && k < u_csp_host.got_q.size(); k++) begin
            check(u_csp_host.got_q[k], exp_q[k], "frame char");
        end
        u_csp_host.got_q.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] v;
        check(cont_mode, 1'b0, "mode after reset");
        check(sleep, 1'b0, "sleep after reset");
        reg_rd(OFF_CTRL, v);
        check(v, 32'h0, "ctrl reset");
        reg_rd(OFF_RANGE, v);
        check(v, 32'h7fff, "range reset");
        reg_rd(OFF_TEMP, v);
        check(v, 32'h0, "temp reset");
        reg_rd(OFF_SELFTEST, v);
        check(v, 32'h3, "selftest reset");
        reg_rd(OFF_IRQ_MASK, v);
        check(v, 32'h0, "mask reset");
        reg_rd(8'h1c, v);
        check(v, 32'h0, "unmapped read");
        reg_rd(OFF_STATE, v);
        check(v, 32'h0, "state reset");
        // With the enable low a status request must leave no trace.
        @(posedge sys_clk);
        ce <= 1'b0;
        u_csp_host.send_byte(CH_STATUS);
        repeat (4) @(posedge sys_clk);
        check(tx_valid, 1'b0, "frozen by enable");
        check(u_csp_host.got_q.size(), 0, "no frame while frozen");
        ce <= 1'b1;
    endtask

    task automatic t_status_default;
        logic [31:0] v;
        u_csp_host.send_byte(CH_STATUS);
        // A second request lands mid-frame and must be dropped, not queued.
        u_csp_host.send_byte(CH_STATUS);
        expect_frame(8'h0a, 16'h7fff, 8'h00, 4'h3, 8'hff, 8'hff);
        reg_rd(OFF_IRQ_STAT, v);
        check(v, 32'hc, "sent and drop events");
        check(irq, 1'b0, "masked irq");
        reg_wr(OFF_IRQ_MASK, 32'h4);
        #1 check(irq, 1'b1, "unmasked irq");
        reg_wr(OFF_IRQ_STAT, 32'h4);
        #1 check(irq, 1'b0, "cleared irq");
    endtask

    task automatic t_sleep;
        logic [31:0] v;
        u_csp_host.send_word("Shutdowx");
        u_csp_host.send_byte(CH_CR);
        #1 check(sleep, 1'b0, "broken word");
        u_csp_host.send_byte(CH_WAKE);
        u_csp_host.send_word("Shutdown");
        u_csp_host.send_byte(CH_CR);
        #1 check(sleep, 1'b1, "shutdown");
        u_csp_host.send_byte(CH_STATUS);
        repeat (40) @(posedge sys_clk);
        check(sleep, 1'b1, "still asleep");
        check(u_csp_host.got_q.size(), 0, "silent while asleep");
        reg_rd(OFF_STATE, v);
        check(v, 32'h1, "asleep state");
        reg_rd(OFF_IRQ_STAT, v);
        check(v & 32'ha, 32'ha, "shutdown and drop events");
        u_csp_host.wake();
        #1 check(sleep, 1'b0, "woken");
        reg_rd(OFF_STATE, v);
        check(v, 32'h2, "settling after wake");
        reg_wr(OFF_IRQ_STAT, 32'hf);
        u_csp_host.send_byte(CH_STATUS);
        u_csp_host.hold_off(HOLD);
        check(u_csp_host.got_q.size(), 0, "no wake reply");
        reg_rd(OFF_IRQ_STAT, v);
        check(v, 32'h8, "dropped in hold-off");
        u_csp_host.send_byte(CH_STATUS);
        expect_frame(8'h0a, 16'h7fff, 8'h00, 4'h3, 8'hff, 8'hff);
    endtask

    // Every rate code, both modes and every pass or fail pairing, with a stalling host.
    task automatic t_status_cfg;
        logic [7:0] rates [4] = '{8'h0a, 8'h05, 8'h01, 8'h00};
        u_csp_host.stall = 1'b1;
        for (int i = 0; i < 4; i++) begin
            reg_wr(OFF_CTRL, {29'h0, i[1:0], i[0]});
            reg_wr(OFF_RANGE, 32'h8001 + 32'(i));
            reg_wr(OFF_TEMP, 32'hf6 - 32'(i));
            reg_wr(OFF_SELFTEST, 32'(i));
            #1 check(cont_mode, i[0], "mode select");
            u_csp_host.send_byte(CH_STATUS);
            expect_frame(rates[i], 16'h8001 + 16'(i), 8'hf6 - 8'(i), i[0] ? 4'h1 : 4'h3,
                         i[0] ? 8'hff : 8'h7f, i[1] ? 8'hff : 8'hfb);
        end
        u_csp_host.stall = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_status_default();
        t_sleep();
        t_status_cfg();
        conclude();
    end
endmodule
